// >>> shared/rcsc_pkg.sv
// Package of constants and types for the reset and clock source control
package rcsc_pkg;
  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned FILTER_TIME_NS = 200;
  localparam int unsigned FILTER_CYCLES =
    (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FILTER_W = 4;
  localparam int unsigned PADS_RC_PULSES = 3;
  localparam int unsigned CORE_XTAL_EDGES = 1024;
  localparam int unsigned CORE_CNT_W = 11;
  localparam int unsigned RC_FREQ_HZ = 10000;
  localparam int unsigned WDOG_TIMEOUT_MS = 2000;
  localparam int unsigned WDOG_WARN_MS = 1750;
  localparam int unsigned WDOG_TIMEOUT_TICKS =
    WDOG_TIMEOUT_MS * RC_FREQ_HZ / 1000;
  localparam int unsigned WDOG_WARN_TICKS = WDOG_WARN_MS * RC_FREQ_HZ / 1000;
  localparam int unsigned WDOG_CNT_W = 15;
  localparam int unsigned DIV_W = 8;
  localparam int unsigned TRIM_W = 4;
  localparam int unsigned PIN_COUNT = 6;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef struct packed {
    logic external_reset_n;
    logic pads_supply_good;
    logic core_supply_good;
    logic rc_clk;
    logic xtal24_clk;
    logic xtal32_clk;
  } rcsc_pins_type;

  typedef struct packed {
    logic power_on;
    logic watchdog;
    logic pc_rollover;
    logic software;
    logic core_dip;
  } rcsc_cause_type;

  localparam rcsc_cause_type CAUSE_NONE = 5'h00;
  localparam rcsc_cause_type CAUSE_POWER_ON = 5'h10;
  localparam rcsc_cause_type CAUSE_WATCHDOG = 5'h08;
  localparam rcsc_cause_type CAUSE_PC_ROLLOVER = 5'h04;
  localparam rcsc_cause_type CAUSE_SOFTWARE = 5'h02;
  localparam rcsc_cause_type CAUSE_CORE_DIP = 5'h01;

  typedef enum logic [1:0] {
    CORE_HOLD = 2'b00,
    CORE_COUNT = 2'b01,
    CORE_RUN = 2'b10
  } rcsc_core_state_type;
endpackage : rcsc_pkg

// >>> rtl/rcsc_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module rcsc_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // ********************************************************************
  // Synchroniser stages
  // ********************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : rcsc_sync
`default_nettype wire

// >>> rtl/rcsc_top.sv
// Reset sequencing, reset cause record and low-frequency clock control
`timescale 1ns/100ps
`default_nettype none
module rcsc_top #(
  parameter int unsigned CORE_EDGES = rcsc_pkg::CORE_XTAL_EDGES,
  parameter int unsigned WDOG_TICKS = rcsc_pkg::WDOG_TIMEOUT_TICKS,
  parameter int unsigned WDOG_WARN = rcsc_pkg::WDOG_WARN_TICKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire rcsc_pkg::rcsc_pins_type pins,
  input wire logic wdog_enable,
  input wire logic wdog_restart,
  input wire logic software_reset_req,
  input wire logic pc_rollover,
  input wire logic [rcsc_pkg::DIV_W-1:0] rc_div_half,
  input wire logic [rcsc_pkg::TRIM_W-1:0] rc_trim_set,
  input wire logic sleep_clk_sel,
  output logic pads_reset_n,
  output logic core_reset_n,
  output rcsc_pkg::rcsc_cause_type reset_cause,
  output logic mgmt_clk,
  output logic sleep_clk,
  output logic wdog_warning,
  output logic [rcsc_pkg::TRIM_W-1:0] rc_trim
);
  // ********************************************************************
  // Reset release and pin synchronisers
  // ********************************************************************
  logic rst_meta_n;
  logic rst_sync_n;
  rcsc_pkg::rcsc_pins_type pin_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  rcsc_sync #(
    .W(rcsc_pkg::PIN_COUNT)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_sync_n),
    .d(pins),
    .q(pin_s)
  );

  // ********************************************************************
  // State
  // ********************************************************************
  logic [rcsc_pkg::FILTER_W-1:0] ext_low_cnt, next_ext_low_cnt;
  logic rc_prev, x24_prev;
  logic [1:0] rc_pulses, next_rc_pulses;
  logic pads_run, next_pads_run;
  rcsc_pkg::rcsc_core_state_type state, next_state;
  logic [rcsc_pkg::CORE_CNT_W-1:0] core_cnt, next_core_cnt;
  logic [rcsc_pkg::WDOG_CNT_W-1:0] wdog_cnt, next_wdog_cnt;
  logic [rcsc_pkg::DIV_W-1:0] div_cnt, next_div_cnt;
  logic cal_clk, next_cal_clk;
  rcsc_pkg::rcsc_cause_type next_cause;
  logic ext_active, rc_rise, x24_rise, hold_core, wdog_fire, core_dip;

  assign ext_active = ext_low_cnt ==
    rcsc_pkg::FILTER_W'(rcsc_pkg::FILTER_CYCLES);
  assign rc_rise = pin_s.rc_clk & ~rc_prev;
  assign x24_rise = pin_s.xtal24_clk & ~x24_prev;
  assign wdog_fire = wdog_enable & rc_rise & (state == rcsc_pkg::CORE_RUN) &
    (wdog_cnt == rcsc_pkg::WDOG_CNT_W'(WDOG_TICKS - 1));
  assign core_dip = (state == rcsc_pkg::CORE_RUN) & ~pin_s.core_supply_good;
  assign hold_core = ~pads_run | ~pin_s.core_supply_good | wdog_fire |
    ((software_reset_req | pc_rollover) &
     (state == rcsc_pkg::CORE_RUN));

  // ********************************************************************
  // Next values
  // ********************************************************************
  always_comb begin
    next_ext_low_cnt = ext_low_cnt;
    if (pin_s.external_reset_n) begin
      next_ext_low_cnt = '0;
    end else if (!ext_active) begin
      next_ext_low_cnt = ext_low_cnt + 1'b1;
    end
    // Pad domain power-on path
    next_rc_pulses = rc_pulses;
    next_pads_run = pads_run;
    if (!pin_s.pads_supply_good || ext_active) begin
      next_rc_pulses = '0;
      next_pads_run = 1'b0;
    end else if (!pads_run && rc_rise) begin
      next_rc_pulses = rc_pulses + 1'b1;
      if (rc_pulses == 2'(rcsc_pkg::PADS_RC_PULSES - 1)) begin
        next_pads_run = 1'b1;
      end
    end
    // Core domain power-on path
    next_state = state;
    next_core_cnt = core_cnt;
    unique case (state)
      rcsc_pkg::CORE_HOLD: begin
        next_core_cnt = '0;
        if (!hold_core) begin
          next_state = rcsc_pkg::CORE_COUNT;
        end
      end
      rcsc_pkg::CORE_COUNT: begin
        if (hold_core) begin
          next_state = rcsc_pkg::CORE_HOLD;
        end else if (x24_rise) begin
          next_core_cnt = core_cnt + 1'b1;
          if (core_cnt == rcsc_pkg::CORE_CNT_W'(CORE_EDGES - 1)) begin
            next_state = rcsc_pkg::CORE_RUN;
          end
        end
      end
      rcsc_pkg::CORE_RUN: begin
        if (hold_core) begin
          next_state = rcsc_pkg::CORE_HOLD;
        end
      end
      default: begin
        next_state = rcsc_pkg::CORE_HOLD;
      end
    endcase
    // Watchdog on the RC clock
    next_wdog_cnt = wdog_cnt;
    if (!wdog_enable || wdog_restart || state != rcsc_pkg::CORE_RUN ||
        wdog_fire) begin
      next_wdog_cnt = '0;
    end else if (rc_rise) begin
      next_wdog_cnt = wdog_cnt + 1'b1;
    end
    // Calibration divider, runs in every state
    next_div_cnt = div_cnt;
    next_cal_clk = cal_clk;
    if (rc_rise) begin
      if (div_cnt + 1'b1 >= rc_div_half) begin
        next_div_cnt = '0;
        next_cal_clk = ~cal_clk;
      end else begin
        next_div_cnt = div_cnt + 1'b1;
      end
    end
    // Cause record, highest priority first
    next_cause = reset_cause;
    if (!pin_s.pads_supply_good) begin
      next_cause = rcsc_pkg::CAUSE_POWER_ON;
    end else if (ext_active) begin
      next_cause = rcsc_pkg::CAUSE_NONE;
    end else if (core_dip) begin
      next_cause = rcsc_pkg::CAUSE_CORE_DIP;
    end else if (wdog_fire) begin
      next_cause = rcsc_pkg::CAUSE_WATCHDOG;
    end else if (software_reset_req && state == rcsc_pkg::CORE_RUN) begin
      next_cause = rcsc_pkg::CAUSE_SOFTWARE;
    end else if (pc_rollover && state == rcsc_pkg::CORE_RUN) begin
      next_cause = rcsc_pkg::CAUSE_PC_ROLLOVER;
    end
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ext_low_cnt <= '0;
      rc_prev <= 1'b0;
      x24_prev <= 1'b0;
      rc_pulses <= '0;
      pads_run <= 1'b0;
      state <= rcsc_pkg::CORE_HOLD;
      core_cnt <= '0;
      wdog_cnt <= '0;
      div_cnt <= '0;
      cal_clk <= 1'b0;
      reset_cause <= rcsc_pkg::CAUSE_POWER_ON;
      pads_reset_n <= 1'b0;
      core_reset_n <= 1'b0;
      mgmt_clk <= 1'b0;
      sleep_clk <= 1'b0;
      wdog_warning <= 1'b0;
      rc_trim <= '0;
    end else begin
      ext_low_cnt <= next_ext_low_cnt;
      rc_prev <= pin_s.rc_clk;
      x24_prev <= pin_s.xtal24_clk;
      rc_pulses <= next_rc_pulses;
      pads_run <= next_pads_run;
      state <= next_state;
      core_cnt <= next_core_cnt;
      wdog_cnt <= next_wdog_cnt;
      div_cnt <= next_div_cnt;
      cal_clk <= next_cal_clk;
      reset_cause <= next_cause;
      pads_reset_n <= pads_run;
      core_reset_n <= (state == rcsc_pkg::CORE_RUN);
      mgmt_clk <= pin_s.rc_clk;
      sleep_clk <= sleep_clk_sel ? pin_s.xtal32_clk : cal_clk;
      wdog_warning <= wdog_enable &
        (wdog_cnt >= rcsc_pkg::WDOG_CNT_W'(WDOG_WARN));
      rc_trim <= rc_trim_set;
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  sequence s_pin_low8;
    (!pin_s.external_reset_n)[*8];
  endsequence

  a_filter_assert: assert property (s_pin_low8 |=> ext_active)
    else $error("Reset pin low 8 cycles not honoured");
  a_filter_glitch: assert property (
    ext_active |-> $past(!pin_s.external_reset_n, 8))
    else $error("Short reset pulse passed the filter");
  a_pads_held: assert property (
    (!pin_s.pads_supply_good || ext_active) |=> ##1 !pads_reset_n)
    else $error("Pad reset released without supply");
  a_pads_pulses: assert property (
    $rose(pads_run) |-> $past(rc_rise) && $past(rc_pulses) == 2'h2)
    else $error("Pad release not on third RC pulse");
  a_core_held: assert property (
    !pin_s.core_supply_good |=> ##1 !core_reset_n)
    else $error("Core reset released with low supply");
  a_core_count: assert property (
    $rose(core_reset_n) |-> $past(core_cnt, 2) ==
      rcsc_pkg::CORE_CNT_W'(CORE_EDGES - 1))
    else $error("Core release not after crystal edge count");
  a_sw_reset: assert property (
    (software_reset_req && state == rcsc_pkg::CORE_RUN) |=>
      ##1 !core_reset_n)
    else $error("Software reset did not reset the core");
  a_wdog_cause: assert property (
    (wdog_fire && pin_s.pads_supply_good && !ext_active && !core_dip) |=>
      reset_cause == rcsc_pkg::CAUSE_WATCHDOG)
    else $error("Watchdog reset not logged");
  a_cause_keep: assert property (
    (state == rcsc_pkg::CORE_RUN && !hold_core && !ext_active &&
     pin_s.pads_supply_good) |=> $stable(reset_cause))
    else $error("Reset cause changed while running");
  a_pads_release: assert property (
    $rose(pads_reset_n) |-> $past(pin_s.pads_supply_good, 2))
    else $error("Pad reset released without supply good");
  a_wdog_reset: assert property (
    wdog_fire |=> ##1 !core_reset_n)
    else $error("Watchdog timeout did not reset the core");
  a_wdog_stopped: assert property (
    state != rcsc_pkg::CORE_RUN |=> wdog_cnt == '0)
    else $error("Watchdog counted outside core run");
  a_pc_reset: assert property (
    (pc_rollover && state == rcsc_pkg::CORE_RUN) |=>
      ##1 !core_reset_n)
    else $error("Counter rollover did not reset the core");
  a_power_cause: assert property (
    !pin_s.pads_supply_good |=> reset_cause == rcsc_pkg::CAUSE_POWER_ON)
    else $error("Power-on cause not logged");
  a_pin_cause: assert property (
    (ext_active && pin_s.pads_supply_good) |=>
      reset_cause == rcsc_pkg::CAUSE_NONE)
    else $error("Pin reset did not clear the cause");
  a_dip_cause: assert property (
    (core_dip && pin_s.pads_supply_good && !ext_active) |=>
      reset_cause == rcsc_pkg::CAUSE_CORE_DIP)
    else $error("Core supply dip not logged");
  a_cause_onehot: assert property ($onehot0(reset_cause))
    else $error("Reset cause holds more than one cause");
  a_mgmt_copy: assert property (
    1'b1 |=> mgmt_clk == $past(pin_s.rc_clk))
    else $error("Management clock not the raw RC clock");
  a_sleep_select: assert property (
    sleep_clk_sel |=> sleep_clk == $past(pin_s.xtal32_clk))
    else $error("Sleep clock select 1 not the 32k clock");
  a_trim_copy: assert property (
    1'b1 |=> rc_trim == $past(rc_trim_set))
    else $error("Trim setting not passed on");
endmodule : rcsc_top
`default_nettype wire

// >>> verif/rcsc_board_model.sv
// Board model: reset pin, supply detectors and oscillators
`timescale 1ns/100ps
`default_nettype none
module rcsc_board_model #(
  parameter int RC_HALF = 10,
  parameter int X32_HALF = 7
) (
  input wire logic clk,
  input wire logic reset_pin_n,
  input wire logic pads_good,
  input wire logic core_good,
  output var rcsc_pkg::rcsc_pins_type pins
);
  // ****************************************************************
  // Oscillators
  // ****************************************************************
  int rc_cnt = 0;
  int x32_cnt = 0;
  int x24_cnt = 0;
  logic rc = 1'b0;
  logic x24 = 1'b0;
  logic x32 = 1'b0;
  always @(posedge clk) begin
    rc_cnt <= (rc_cnt == RC_HALF - 1) ? 0 : rc_cnt + 1;
    x32_cnt <= (x32_cnt == X32_HALF - 1) ? 0 : x32_cnt + 1;
    x24_cnt <= (x24_cnt == 1) ? 0 : x24_cnt + 1;
    if (rc_cnt == RC_HALF - 1) rc <= ~rc;
    if (x32_cnt == X32_HALF - 1) x32 <= ~x32;
    if (x24_cnt == 1) x24 <= ~x24;
  end
  // Pin passed through as the bench drives it, short glitches included
  assign pins = {reset_pin_n, pads_good, core_good, rc, x24, x32};
endmodule : rcsc_board_model
`default_nettype wire

// >>> verif/tb_rcsc_top.sv
// Self-checking bench for the reset and clock source control
`timescale 1ns/100ps
`default_nettype none
module tb_rcsc_top;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int CORE_EDGES = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pin_n = 1'b1;
  logic pads_good = 1'b0;
  logic core_good = 1'b0;
  logic wdog_enable = 1'b0;
  logic wdog_restart = 1'b0;
  logic sw_req = 1'b0;
  logic pc_req = 1'b0;
  logic [rcsc_pkg::TRIM_W-1:0] trim_set = 4'h0;
  logic clk_sel = 1'b0;
  rcsc_pkg::rcsc_pins_type pins;
  logic pads_reset_n;
  logic core_reset_n;
  rcsc_pkg::rcsc_cause_type reset_cause;
  logic mgmt_clk;
  logic sleep_clk;
  logic wdog_warning;
  logic [rcsc_pkg::TRIM_W-1:0] rc_trim;
  int num_errors = 0;
  int tests_run = 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  rcsc_board_model board (.clk(clk), .reset_pin_n(pin_n),
    .pads_good(pads_good), .core_good(core_good), .pins(pins));
  rcsc_top #(.CORE_EDGES(CORE_EDGES), .WDOG_TICKS(20), .WDOG_WARN(15)) dut (
    .clk(clk), .rst_n(rst_n), .pins(pins), .wdog_enable(wdog_enable),
    .wdog_restart(wdog_restart), .software_reset_req(sw_req),
    .pc_rollover(pc_req),
    .rc_div_half(8'h02), .rc_trim_set(trim_set), .sleep_clk_sel(clk_sel),
    .pads_reset_n(pads_reset_n), .core_reset_n(core_reset_n),
    .reset_cause(reset_cause), .mgmt_clk(mgmt_clk), .sleep_clk(sleep_clk),
    .wdog_warning(wdog_warning), .rc_trim(rc_trim));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  function automatic logic pick(input int which);
    case (which)
      0: return pads_reset_n;
      1: return core_reset_n;
      2: return wdog_warning;
      3: return sleep_clk;
      default: return mgmt_clk;
    endcase
  endfunction : pick
  task automatic wait_lvl(input int which, input logic v, input int max,
    output int n);
    n = 0;
    while (pick(which) !== v) begin
      step(1);
      n++;
      if (n > max) begin
        num_errors++;
        $display("[ERR] wait %0d expected %0h seen timeout", which, v);
        report_and_stop();
      end
    end
  endtask : wait_lvl
  task automatic wait_up();
    int n;
    wait_lvl(0, 1'b1, 400, n);
    wait_lvl(1, 1'b1, 400, n);
  endtask : wait_up
  task automatic half_period(input int which, output int n);
    logic v;
    int k;
    v = pick(which);
    wait_lvl(which, !v, 400, k);
    wait_lvl(which, v, 400, n);
  endtask : half_period
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_power_up();
    int n;
    check("cause", reset_cause, rcsc_pkg::CAUSE_POWER_ON);
    check("pads", pads_reset_n, 1'b0);
    pads_good = 1'b1;
    wait_lvl(0, 1'b1, 200, n);
    check("pads wait", n >= 40, 1'b1);
    step(40);
    check("core held", core_reset_n, 1'b0);
    core_good = 1'b1;
    wait_lvl(1, 1'b1, 200, n);
    check("core count", n >= CORE_EDGES * 4 - 4, 1'b1);
    check("cause kept", reset_cause, rcsc_pkg::CAUSE_POWER_ON);
    $display("power up test done");
  endtask : t_power_up
  task automatic t_pin();
    pin_n = 1'b0;
    step(5);
    pin_n = 1'b1;
    step(20);
    check("glitch", pads_reset_n, 1'b1);
    pin_n = 1'b0;
    step(16);
    check("pin pads", pads_reset_n, 1'b0);
    check("pin core", core_reset_n, 1'b0);
    check("pin cause", reset_cause, rcsc_pkg::CAUSE_NONE);
    pin_n = 1'b1;
    wait_up();
    $display("pin test done");
  endtask : t_pin
  task automatic t_event(input int kind, input rcsc_pkg::rcsc_cause_type exp);
    int n;
    sw_req = (kind == 0);
    pc_req = (kind == 1);
    core_good = (kind != 2);
    wdog_enable = (kind == 3);
    if (kind < 2) step(1);
    sw_req = 1'b0;
    pc_req = 1'b0;
    if (kind == 3) begin
      step(200);
      check("wdog early", wdog_warning, 1'b0);
      wdog_restart = 1'b1;
      step(1);
      wdog_restart = 1'b0;
      wait_lvl(2, 1'b1, 400, n);
      check("wdog warn", n >= 280 && n <= 305, 1'b1);
    end
    wait_lvl(1, 1'b0, 200, n);
    if (kind == 3) check("wdog fire", n >= 96 && n <= 104, 1'b1);
    check("event cause", reset_cause, exp);
    check("pads kept", pads_reset_n, 1'b1);
    core_good = 1'b1;
    wdog_enable = 1'b0;
    wait_up();
    check("cause after", reset_cause, exp);
    $display("event test %0d done", kind);
  endtask : t_event
  task automatic t_clocks();
    int n;
    trim_set = 4'hA;
    step(6);
    check("trim", rc_trim, 4'hA);
    half_period(4, n);
    check("mgmt half", n, 10);
    half_period(3, n);
    check("cal half", n, 40);
    clk_sel = 1'b1;
    step(5);
    half_period(3, n);
    check("x32 half", n, 7);
    $display("clock test done");
  endtask : t_clocks
  initial begin
    step(10);
    rst_n = 1'b1;
    step(3);
    t_power_up();
    t_pin();
    t_event(0, rcsc_pkg::CAUSE_SOFTWARE);
    t_event(1, rcsc_pkg::CAUSE_PC_ROLLOVER);
    t_event(2, rcsc_pkg::CAUSE_CORE_DIP);
    t_event(3, rcsc_pkg::CAUSE_WATCHDOG);
    t_clocks();
    report_and_stop();
  end
endmodule : tb_rcsc_top
`default_nettype wire
